// ==== rtl/mmd_memory_map_decoder.sv ====
// Memory map decoder: routes fetch and data accesses to their targets.
// Assumes requests, strap and protection inputs share core_clk.
`timescale 1ns/1ps

// Overview of operation
// [RQ1] One linear 16 MB space, 64 KB segments.
// [RQ2] Byte and word access everywhere.
// [RQ3] Shaded reserved areas go external when present; the PB_RSV2_LO area goes external even without the bus.
// [RQ4] Internal data memories decode in segment zero.
// [RQ5] Instruction fetches handled by program fetch unit.
// [RQ6] Data transfers handled by data transfer unit.
// [RQ7] Cross-unit accesses use the system bus.
// [RQ8] System bus carries both directions concurrently.
// [RQ9] Program SRAM via fetch unit, write-protectable region.
// [RQ10] Data SRAM through its own interface.
// [RQ11] Dual-port RAM holds register banks.
// [RQ12] Top 256 bytes and GPRs bit addressable.
// [RQ13] Two 512-byte register spaces decoded.
// [RQ14] Software avoids unused register addresses.
// [RQ15] Standby SRAM own interface, standby powered.
// [RQ16] Flash modules split into 4 KB sectors.
// [RQ17] Sectors write-protectable; 128-byte programming blocks.
// [RQ18] Top sector of first segment kept internal.
// [RQ19] Flash read protect, password unlocks temporarily.
// [RQ20] 128-bit flash reads, parallel module access.
// [RQ21] External IO region disables pipeline optimisations.
// [RQ22] Every address mapped; trap ranges flagged.
module mmd_memory_map_decoder #(
	parameter int FL_SECT_N = mmd_pkg::FL_SECTORS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic ext_bus_present,
	input wire mmd_pkg::mmd_req_s fetch_req,
	input wire mmd_pkg::mmd_req_s data_req,
	input wire logic [23:0] gpr_cp,
	input wire logic [5:0] program_sram_wp_kb,
	input wire logic flash_rd_prot,
	input wire logic [FL_SECT_N-1:0] flash_sect_wp,
	input wire logic [15:0] pw_key1,
	input wire logic [15:0] pw_key2,
	output mmd_pkg::mmd_route_s fetch_route,
	output mmd_pkg::mmd_route_s data_route,
	output logic flash_unlocked
);
	import mmd_pkg::*;

	////////////////////////////////////////////////////////////////////
	// State and helper functions.
	////////////////////////////////////////////////////////////////////

	// All state of the decoder lives in this one record.
	typedef struct packed {
		mmd_route_s fetch;
		mmd_route_s data;
		mmd_pw_e pw;
	} mmd_state_s;

	mmd_state_s st_r; // Registered state.
	mmd_state_s st_nxt; // Next state.

	// Map one address onto its target. Shared by both request paths.
	function automatic mmd_tgt_e mmd_decode(input logic [23:0] a,
		input logic ext_ok);
		mmd_tgt_e rsv;
		rsv = ext_ok ? MMD_EXT : MMD_NONE; // [RQ3]
		if (a >= IMB_LO) begin
			mmd_decode = MMD_IMB;
		end else if (a >= TRAP_LO) begin
			mmd_decode = MMD_TRAP; // [RQ22]
		end else if (a >= EPS_LO) begin
			mmd_decode = MMD_EMULATED_PROGRAM_SRAM; // Mirror folds onto the copy.
		end else if (a >= PS_LO) begin
			mmd_decode = MMD_PROGRAM_SRAM; // [RQ9]
		end else if (a >= FL_RSV_LO) begin
			mmd_decode = rsv;
		end else if (a >= FL_LO) begin
			mmd_decode = MMD_FLASH; // [RQ16]
		end else if (a >= PB_RSV2_LO) begin
			mmd_decode = MMD_EXT; // Reserved hole 2, upper external and IO areas.
		end else if (a >= PB_ALT_LO) begin
			mmd_decode = MMD_PBUS;
		end else if (a >= PB_RSV1_LO) begin
			mmd_decode = rsv;
		end else if (a >= PB_LO) begin
			mmd_decode = MMD_PBUS;
		end else if (a >= EXT_MID_LO) begin
			mmd_decode = MMD_EXT;
		end else if (a >= SFR_LO) begin
			mmd_decode = MMD_SFR; // [RQ4] [RQ13]
		end else if (a >= DP_LO) begin
			mmd_decode = MMD_DUAL_PORT_RAM; // [RQ4]
		end else if (a >= DP_RSV_LO) begin
			mmd_decode = rsv;
		end else if (a >= EXTENDED_FUNCTION_REGS_LO) begin
			mmd_decode = MMD_EXTENDED_FUNCTION_REGS; // [RQ13]
		end else if (a >= EXTERNAL_SIDE_FUNCTION_REGS_LO) begin
			mmd_decode = MMD_EXTERNAL_SIDE_FUNCTION_REGS;
		end else if (a >= DS_LO) begin
			mmd_decode = MMD_DATA_SRAM; // [RQ10]
		end else if (a >= SB_LO) begin
			mmd_decode = MMD_STANDBY_SRAM; // [RQ15]
		end else begin
			mmd_decode = MMD_EXT;
		end
	endfunction

	// True for targets owned by the program fetch unit.
	function automatic logic mmd_is_prog(input mmd_tgt_e t);
		mmd_is_prog = (t == MMD_FLASH) || (t == MMD_PROGRAM_SRAM) ||
			(t == MMD_EMULATED_PROGRAM_SRAM);
	endfunction

	// Flash module number from the address.
	function automatic logic [1:0] mmd_fmod(input logic [23:0] a);
		mmd_fmod = a[19:18];
	endfunction

	// Build a full route for one request.
	function automatic mmd_route_s mmd_route(input mmd_req_s rq,
		input logic [23:0] a, input logic is_fetch,
		input logic ext_ok, input logic [5:0] wp_kb,
		input logic rd_prot, input logic open_pw,
		input logic [FL_SECT_N-1:0] sect_wp);
		mmd_route_s r;
		logic [7:0] gsect;
		logic [15:0] wp_lim;
		r = '0;
		r.valid = rq.valid;
		r.tgt = mmd_decode(a, ext_ok); // [RQ1] [RQ22]
		// Words sit on even addresses; bytes pick a lane.
		r.addr = rq.word ? {a[23:1], 1'b0} : a; // [RQ2]
		r.be = rq.word ? 2'b11 : (a[0] ? 2'b10 : 2'b01); // [RQ2]
		// Fetches to data-side targets and data to program memory
		// both cross over the system bus.
		r.sysbus = (r.tgt != MMD_NONE) &&
			(is_fetch != mmd_is_prog(r.tgt)); // [RQ5] [RQ6] [RQ7]
		r.ext_io = (a >= EXT_IO_LO) && (a <= EXT_IO_HI); // [RQ21]
		r.trap = (r.tgt == MMD_TRAP) ||
			((a >= FL_INT_LO) && (a <= FL_INT_HI)); // [RQ18]
		r.bit_addr = rq.general_purpose_register || ((r.tgt == MMD_DUAL_PORT_RAM) &&
			(a >= DP_BIT_LO)); // [RQ12]
		r.fmod = mmd_fmod(a);
		r.fsect = a[17:12]; // [RQ16]
		r.fline = a[23:4]; // [RQ20]
		gsect = {r.fmod, r.fsect};
		wp_lim = {wp_kb, 10'h000};
		if (rq.write && (r.tgt == MMD_PROGRAM_SRAM) &&
			(a[15:0] < wp_lim)) begin
			r.wr_block = 1'b1; // [RQ9]
		end
		if (rq.write && (r.tgt == MMD_FLASH) &&
			(a != PW_ADDR) && sect_wp[gsect]) begin
			r.wr_block = 1'b1; // [RQ17]
		end
		// Only data reads are fenced; code keeps running from flash.
		if (!is_fetch && !rq.write && (r.tgt == MMD_FLASH) &&
			rd_prot && !open_pw) begin
			r.rd_block = 1'b1; // [RQ19]
		end
		mmd_route = r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Next-state logic.
	////////////////////////////////////////////////////////////////////

	logic [23:0] gpr_addr; // Register bank address for GENERAL_PURPOSE_REGISTER accesses.
	logic [23:0] data_addr; // Effective data address.
	logic pw_hit; // Data write to the unlock location.
	logic pw_open; // Unlock currently granted.

	// Register bank addressing: words at 2n, bytes low/high of 0..7.
	always_comb begin
		gpr_addr = '0;
		if (data_req.gpr_hi || !data_req.word) begin
			gpr_addr = gpr_cp + {19'h0, 1'b0, data_req.gpr_num[2:0],
				data_req.gpr_hi}; // [RQ11]
		end else begin
			gpr_addr = gpr_cp + {19'h0, data_req.gpr_num,
				1'b0}; // [RQ11]
		end
		data_addr = data_req.general_purpose_register ? gpr_addr : data_req.addr;
	end

	// Decode both paths and run the unlock sequencer.
	always_comb begin
		st_nxt = st_r;
		pw_open = (st_r.pw == MMD_PW_OPEN);
		pw_hit = data_req.valid && data_req.write && data_req.word &&
			!data_req.general_purpose_register && (data_req.addr == PW_ADDR);
		// Fetch and data paths decode in the same cycle; the system
		// bus may carry one transfer each way at once.
		st_nxt.fetch = mmd_route(fetch_req, fetch_req.addr, 1'b1,
			ext_bus_present, program_sram_wp_kb, flash_rd_prot, pw_open,
			flash_sect_wp); // [RQ5] [RQ8]
		st_nxt.data = mmd_route(data_req, data_addr, 1'b0,
			ext_bus_present, program_sram_wp_kb, flash_rd_prot, pw_open,
			flash_sect_wp); // [RQ6] [RQ8]
		// One flash module serves one 128-bit read at a time; the
		// data side waits when both sides hit the same module.
		if (fetch_req.valid && data_req.valid &&
			(st_nxt.fetch.tgt == MMD_FLASH) &&
			(st_nxt.data.tgt == MMD_FLASH) &&
			(st_nxt.fetch.fmod == st_nxt.data.fmod)) begin
			st_nxt.data.stall = 1'b1; // [RQ20]
		end
		// Two keyed writes open flash; any later word write to PW_ADDR relocks.
		case (st_r.pw)
			MMD_PW_IDLE: begin
				if (pw_hit && (data_req.wdata == pw_key1)) begin
					st_nxt.pw = MMD_PW_KEY1; // [RQ19]
				end
			end
			MMD_PW_KEY1: begin
				if (pw_hit && (data_req.wdata == pw_key2)) begin
					st_nxt.pw = MMD_PW_OPEN; // [RQ19]
				end else if (pw_hit) begin
					st_nxt.pw = MMD_PW_IDLE;
				end
			end
			MMD_PW_OPEN: begin
				if (pw_hit) begin
					st_nxt.pw = MMD_PW_IDLE; // [RQ19]
				end
			end
			default: begin
				st_nxt.pw = MMD_PW_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register.
	////////////////////////////////////////////////////////////////////

	// Synchronous reset; clock enable low freezes everything.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state flops.
	assign fetch_route = st_r.fetch;
	assign data_route = st_r.data;
	assign flash_unlocked = (st_r.pw == MMD_PW_OPEN);

endmodule // mmd_memory_map_decoder

// ==== rtl/mmd_pkg.sv ====
// Shared constants and types for the memory map decoder.
// Assumes one system clock and that all inputs are on that clock.
package mmd_pkg;

	// Address space layout: 256 segments of 64 KB, pages of 16 KB.
	localparam int ADDR_W = 24;
	localparam int SEG_COUNT = 256;
	localparam int SEG_BYTES = 65536;
	localparam int PAGE_BYTES = 16384;

	// Region bounds, inclusive start and end.
	localparam logic [23:0] IMB_LO = 24'hff_ff00;
	localparam logic [23:0] TRAP_LO = 24'hf0_0000;
	localparam logic [23:0] EPS_MIR_LO = 24'he8_8000;
	localparam logic [23:0] EPS_LO = 24'he8_0000;
	localparam logic [23:0] PS_MIR_LO = 24'he0_8000;
	localparam logic [23:0] PS_LO = 24'he0_0000;
	localparam logic [23:0] FL_RSV_LO = 24'hcd_0000;
	localparam logic [23:0] FL_LO = 24'hc0_0000;
	localparam logic [23:0] FL_INT_LO = 24'hc0_f000;
	localparam logic [23:0] FL_INT_HI = 24'hc0_ffff;
	localparam logic [23:0] EXT_HI_LO = 24'h40_0000;
	localparam logic [23:0] EXT_IO_LO = 24'h21_0000;
	localparam logic [23:0] EXT_IO_HI = 24'h3f_ffff;
	localparam logic [23:0] PB_RSV2_LO = 24'h20_c000;
	localparam logic [23:0] PB_ALT_LO = 24'h20_8000;
	localparam logic [23:0] PB_RSV1_LO = 24'h20_6000;
	localparam logic [23:0] PB_LO = 24'h20_0000;
	localparam logic [23:0] EXT_MID_LO = 24'h01_0000;
	localparam logic [23:0] SFR_LO = 24'h00_fe00;
	localparam logic [23:0] DP_LO = 24'h00_f600;
	localparam logic [23:0] DP_BIT_LO = 24'h00_fd00;
	localparam logic [23:0] DP_RSV_LO = 24'h00_f200;
	localparam logic [23:0] EXTENDED_FUNCTION_REGS_LO = 24'h00_f000;
	localparam logic [23:0] EXTERNAL_SIDE_FUNCTION_REGS_LO = 24'h00_e000;
	localparam logic [23:0] DS_LO = 24'h00_a000;
	localparam logic [23:0] SB_LO = 24'h00_8000;

	// Flash unlock command location.
	localparam logic [23:0] PW_ADDR = 24'hc0_0aaa;
	localparam int FL_SECT_W = 6;
	localparam int FL_SECTORS = 256;
	localparam int FL_PROG_BYTES = 128;
	localparam int PSWP_UNIT_SH = 10;

	// Route targets.
	typedef enum logic [3:0] {
		MMD_NONE, MMD_IMB, MMD_TRAP, MMD_EMULATED_PROGRAM_SRAM, MMD_PROGRAM_SRAM,
		MMD_FLASH, MMD_EXT, MMD_PBUS, MMD_SFR, MMD_EXTENDED_FUNCTION_REGS,
		MMD_EXTERNAL_SIDE_FUNCTION_REGS, MMD_DUAL_PORT_RAM, MMD_DATA_SRAM, MMD_STANDBY_SRAM
	} mmd_tgt_e;

	// Password unlock sequencer states.
	typedef enum logic [1:0] {
		MMD_PW_IDLE, MMD_PW_KEY1, MMD_PW_OPEN
	} mmd_pw_e;

	// One access request from the CPU.
	typedef struct packed {
		logic valid;
		logic write;
		logic word;
		logic general_purpose_register;
		logic [3:0] gpr_num;
		logic gpr_hi;
		logic [23:0] addr;
		logic [15:0] wdata;
	} mmd_req_s;

	// Decoded route for one request.
	typedef struct packed {
		logic valid;
		mmd_tgt_e tgt;
		logic [23:0] addr;
		logic [1:0] be;
		logic sysbus;
		logic ext_io;
		logic trap;
		logic wr_block;
		logic rd_block;
		logic bit_addr;
		logic stall;
		logic [1:0] fmod;
		logic [5:0] fsect;
		logic [19:0] fline;
	} mmd_route_s;

endpackage

// ==== testbench/mmd_assertions.sv ====
// Port checks for the memory map decoder, bound into every instance.
// Assumes one clock domain and the registered one-cycle route output.
`timescale 1ns/1ps
module mmd_assertions
	import mmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic ext_bus_present,
	input wire mmd_pkg::mmd_req_s fetch_req,
	input wire mmd_pkg::mmd_req_s data_req,
	input wire logic [15:0] pw_key1,
	input wire logic [15:0] pw_key2,
	input wire mmd_pkg::mmd_route_s fetch_route,
	input wire mmd_pkg::mmd_route_s data_route,
	input wire logic flash_unlocked
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Plain data access taken this edge, its address, and unlock writes.
	logic dv;
	logic pw;
	logic [23:0] da;
	assign dv = clk_en && data_req.valid && !data_req.general_purpose_register;
	assign da = data_req.addr;
	assign pw = dv && data_req.write && data_req.word && da == PW_ADDR;
	// A write that is neither key returns the sequencer to idle.
	sequence s_clear;
		pw && data_req.wdata != pw_key1 && data_req.wdata != pw_key2;
	endsequence
	sequence s_key1; pw && data_req.wdata == pw_key1; endsequence
	sequence s_key2; pw && data_req.wdata == pw_key2; endsequence
	route_valid_a: assert property (clk_en |=>
		data_route.valid == $past(data_req.valid) &&
		fetch_route.valid == $past(fetch_req.valid))
		else $error("Route valid does not follow request.");
	word_pair_a: assert property (dv && data_req.word |=>
		data_route.be == 2'b11 && !data_route.addr[0])
		else $error("Word access lanes wrong.");
	byte_lane_a: assert property (dv && !data_req.word |=>
		data_route.be == ($past(da[0]) ? 2'b10 : 2'b01))
		else $error("Byte access lane wrong.");
	data_sram_tgt_a: assert property (dv && da inside {[DS_LO:24'h00_dfff]}
		|=> data_route.tgt == MMD_DATA_SRAM && !data_route.sysbus)
		else $error("Data SRAM not routed directly.");
	ext_io_a: assert property (dv && da inside {[EXT_IO_LO:EXT_IO_HI]}
		|=> data_route.ext_io && data_route.tgt == MMD_EXT)
		else $error("External IO access not marked.");
	rsv_fwd_a: assert property (dv && da inside {[PB_RSV1_LO:24'h20_7fff]}
		|=> data_route.tgt == ($past(ext_bus_present) ? MMD_EXT : MMD_NONE))
		else $error("Reserved access not forwarded.");
	trap_flag_a: assert property (clk_en && fetch_req.valid &&
		fetch_req.addr inside {[TRAP_LO:24'hff_feff]} |=> fetch_route.trap)
		else $error("Trap range not flagged.");
	flash_sys_a: assert property (dv && da inside {[FL_LO:24'hcc_ffff]}
		|=> data_route.tgt == MMD_FLASH && data_route.sysbus)
		else $error("Data flash read not on system bus.");
	unlock_seq_a: assert property (s_clear ##1 !pw [*3] ##1 s_key1
		##1 !pw [*3] ##1 s_key2 |=> flash_unlocked)
		else $error("Password sequence did not unlock.");
	relock_a: assert property (flash_unlocked && pw |=>
		!flash_unlocked) else $error("Flash did not relock.");
endmodule // mmd_assertions
bind mmd_memory_map_decoder mmd_assertions i_chk (.core_clk(core_clk),
	.rst_b(rst_b), .clk_en(clk_en), .ext_bus_present(ext_bus_present),
	.fetch_req(fetch_req), .data_req(data_req), .pw_key1(pw_key1),
	.pw_key2(pw_key2), .fetch_route(fetch_route),
	.data_route(data_route), .flash_unlocked(flash_unlocked));

// ==== testbench/mmd_cpu_model.sv ====
// CPU stand-in issuing one fetch and one data request per call.
// Assumes the decoder samples requests on the rising clock edge.
`timescale 1ns/1ps
module mmd_cpu_model
	import mmd_pkg::*;
(
	input wire logic core_clk,
	output mmd_pkg::mmd_req_s fetch_req,
	output mmd_pkg::mmd_req_s data_req
);
	initial begin
		fetch_req = '0;
		data_req = '0;
	end
	// Holds both requests over one edge, then drops valid and inverts
	// the rest, so a stale field can never pass for a fresh one.
	task automatic issue(input mmd_req_s f, input mmd_req_s d);
		@(negedge core_clk);
		fetch_req = f;
		data_req = d;
		@(posedge core_clk);
		@(negedge core_clk);
		fetch_req = {1'b0, ~f[$bits(f)-2:0]};
		data_req = {1'b0, ~d[$bits(d)-2:0]};
	endtask
endmodule // mmd_cpu_model

// ==== testbench/tb.sv ====
// Self-checking bench for the memory map decoder.
// Assumes the CPU model drives requests on the falling edge.
`timescale 1ns/1ps
module tb;
	import mmd_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic ext_bus_present = 1'b1;
	logic [23:0] gpr_cp = 24'h00_f600;
	logic [5:0] program_sram_wp_kb = 6'h02;
	logic flash_rd_prot = 1'b0;
	logic [255:0] flash_sect_wp = 256'h2;
	logic [15:0] pw_key1 = 16'h5a3c;
	logic [15:0] pw_key2 = 16'hc3a5;
	mmd_req_s fq;
	mmd_req_s dq;
	mmd_route_s fr;
	mmd_route_s dr;
	logic unl;
	int errors = 0;
	int check_count = 0;
	always #2 core_clk = ~core_clk;
	mmd_cpu_model i_cpu (.core_clk(core_clk), .fetch_req(fq),
		.data_req(dq));
	mmd_memory_map_decoder i_dut (.core_clk(core_clk), .rst_b(rst_b),
		.clk_en(clk_en), .ext_bus_present(ext_bus_present),
		.fetch_req(fq), .data_req(dq), .gpr_cp(gpr_cp),
		.program_sram_wp_kb(program_sram_wp_kb), .flash_rd_prot(flash_rd_prot),
		.flash_sect_wp(flash_sect_wp), .pw_key1(pw_key1),
		.pw_key2(pw_key2), .fetch_route(fr), .data_route(dr),
		.flash_unlocked(unl));
	////////////////////////////////////////////////////////////////////
	function automatic mmd_req_s rq(logic w, logic wd, logic [23:0] a,
		logic [15:0] d);
		rq = '0;
		rq.valid = 1'b1;
		rq.write = w;
		rq.word = wd;
		rq.addr = a;
		rq.wdata = d;
	endfunction
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Reads across the map; only mapped register words are touched.
	task automatic t_map();
		logic [23:0] a[17] = '{24'hff_ff00, 24'hf0_0000, 24'he8_8000,
			24'he0_8000, 24'hc0_0000, 24'hcc_ffff, 24'h40_0000, 24'h20_8000,
			24'h20_5fff, 24'h01_0000, 24'h00_fe00, 24'h00_fdff, 24'h00_f000,
			24'h00_efff, 24'h00_a000, 24'h00_9fff, 24'h00_7fff};
		mmd_tgt_e t[17] = '{MMD_IMB, MMD_TRAP, MMD_EMULATED_PROGRAM_SRAM, MMD_PROGRAM_SRAM,
			MMD_FLASH, MMD_FLASH, MMD_EXT, MMD_PBUS, MMD_PBUS, MMD_EXT,
			MMD_SFR, MMD_DUAL_PORT_RAM, MMD_EXTENDED_FUNCTION_REGS, MMD_EXTERNAL_SIDE_FUNCTION_REGS, MMD_DATA_SRAM, MMD_STANDBY_SRAM,
			MMD_EXT};
		for (int i = 0; i < 17; i++) begin
			i_cpu.issue('0, rq(1'b0, 1'b1, a[i], 16'h0));
			chk("target", 24'(dr.tgt), 24'(t[i]));
		end
	endtask
	// The flash reserved hole goes external only when the bus is fitted.
	task automatic t_rsv();
		for (int e = 0; e < 2; e++) begin
			ext_bus_present = e[0];
			i_cpu.issue('0, rq(1'b0, 1'b0, 24'hcd_0000, 16'h0));
			chk("reserved", 24'(dr.tgt), 24'(e ? MMD_EXT : MMD_NONE));
		end
	endtask
	// Lanes, both units at once, flash module clash and line index.
	task automatic t_bus();
		i_cpu.issue('0, rq(1'b0, 1'b1, 24'h00_a003, 16'h0));
		chk("word lanes", {dr.be, dr.addr[21:0]}, 24'hc0_a002);
		i_cpu.issue('0, rq(1'b0, 1'b0, 24'h00_a003, 16'h0));
		chk("byte lanes", 24'(dr.be), 24'h2);
		i_cpu.issue(rq(1'b0, 1'b1, 24'hc0_0000, 16'h0),
			rq(1'b0, 1'b1, 24'hc0_1000, 16'h0));
		chk("fetch path", {fr.valid, fr.sysbus, dr.valid}, 24'h5);
		chk("clash", {dr.stall, dr.sysbus, dr.fsect}, 24'hc1);
		i_cpu.issue(rq(1'b0, 1'b1, 24'hc4_0010, 16'h0),
			rq(1'b0, 1'b1, 24'h00_a000, 16'h0));
		chk("no clash", {dr.stall, fr.fline}, 24'hc4001);
		i_cpu.issue(rq(1'b0, 1'b1, 24'h00_a000, 16'h0), '0);
		chk("fetch data", {fr.tgt, fr.sysbus}, {MMD_DATA_SRAM, 1'b1});
	endtask
	// Write protection, internal sector and register bank addressing.
	task automatic t_prot();
		mmd_req_s g;
		logic [23:0] a[4] = '{24'he0_07fe, 24'he0_0800, 24'hc0_1000,
			24'hc0_2000};
		for (int i = 0; i < 4; i++) begin
			i_cpu.issue('0, rq(1'b1, 1'b1, a[i], 16'h0));
			chk("write block", 24'(dr.wr_block), 24'(i % 2 == 0));
		end
		i_cpu.issue('0, rq(1'b0, 1'b0, 24'hc0_f000, 16'h0));
		chk("internal", 24'(dr.trap), 24'h1);
		g = rq(1'b0, 1'b0, 24'h0, 16'h0);
		g.general_purpose_register = 1'b1;
		g.gpr_num = 4'h3;
		g.gpr_hi = 1'b1;
		i_cpu.issue('0, g);
		chk("bank byte", {dr.bit_addr, dr.be, dr.addr[19:0]},
			24'h60_f607);
	endtask
	// Clock enable low freezes the routes; a mid-run reset clears them.
	task automatic t_hold();
		i_cpu.issue('0, rq(1'b0, 1'b1, 24'h00_a000, 16'h0));
		chk("before hold", 24'(dr.tgt), 24'(MMD_DATA_SRAM));
		clk_en = 1'b0;
		i_cpu.issue('0, rq(1'b0, 1'b1, 24'h00_fe00, 16'h0));
		chk("hold", 24'(dr.tgt), 24'(MMD_DATA_SRAM));
		clk_en = 1'b1;
		rst_b = 1'b0;
		@(negedge core_clk);
		chk("mid reset", {dr.valid, unl, dr.tgt}, 24'h0);
		rst_b = 1'b1;
	endtask
	// Read protection held open only by the password sequence.
	task automatic t_pw();
		logic [15:0] k[4] = '{16'h0, pw_key1, pw_key2, 16'h0};
		flash_rd_prot = 1'b1;
		for (int i = 0; i < 4; i++) begin
			i_cpu.issue('0, rq(1'b1, 1'b1, PW_ADDR, k[i]));
			chk("unlock", 24'(unl), 24'(i == 2));
			i_cpu.issue('0, rq(1'b0, 1'b1, 24'hc0_0000, 16'h0));
			chk("read block", 24'(dr.rd_block), 24'(i != 2));
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge core_clk);
		chk("reset", {dr.valid, fr.valid, unl, dr.tgt}, 24'h0);
		rst_b = 1'b1;
		t_map();
		t_rsv();
		t_bus();
		t_prot();
		t_hold();
		t_pw();
		tally_and_finish();
	end
	// Cuts a hang short.
	initial begin
		repeat (2000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
endmodule // tb
